// ---- logic/jtag_access_pkg.sv ----
// Constants shared by the test register access port and its helpers.
// Assumes a single design clock that oversamples the test clock pins.
package jtag_access_pkg;
  localparam int IR_W = 54;
  localparam logic [IR_W-1:0] IR_ACCESS = 54'h3F_FFFF_FFFF_FFFD;
  localparam logic [IR_W-1:0] IR_BYPASS = {IR_W{1'b1}};
  localparam logic [IR_W-1:0] IR_CAPTURE = 54'h00_0000_0000_0001;
  localparam int DR_W = 69;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int ADDR_LO = 54;
  localparam int DIR_POS = 53;
  localparam int WDATA_LO = 21;
  localparam int READY_POS = 0;
  localparam int ERROR_POS = 1;
  localparam int RDATA_LO = 2;
  localparam int IDLE_MIN_TCK = 20;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
  } tap_state_t;
endpackage

// ---- logic/sync2.sv ----
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time relative to clk_i.
`timescale 1ns/100ps
`default_nettype none
module sync2 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_r <= 1'b0;
      q_o <= 1'b0;
    end
    else if (ce_i)
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- logic/jtag_register_access_port.sv ----
// Test access port with a user scan register that reaches the bridge registers.
// Assumes test pins arrive asynchronously and the register port answers in one cycle.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Scan register reads and writes bridge registers.
// - Address field is a word index.
// - Shift least significant bit first.
// - Ready shifts out first, error second.
// - Read data follows the two flags.
// - One scan register serves reads and writes.
// - Compliance pin selects single or chained TAP.
// - Chain routes SerDes output into top TAP.
// - Scan enable and tristate test inputs honoured.
// - Reset pin or five TMS-high clocks reset TAP.
// - Unknown instructions act as bypass.
module jtag_register_access_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic test_reset_pin_n_i,
  input wire logic compliance_enable_pin_i,
  input wire logic serdes_tdo_i,
  input wire logic scan_shift_enable_i,
  input wire logic global_tristate_pin_i,
  output logic serdes_tdi_o,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic scan_mode_o,
  output logic bidir_force_input_o,
  output logic cfg_wr_o,
  output logic cfg_rd_o,
  output logic [jtag_access_pkg::ADDR_W-1:0] cfg_addr_o,
  output logic [jtag_access_pkg::DATA_W-1:0] cfg_wdata_o,
  input wire logic [jtag_access_pkg::DATA_W-1:0] cfg_rdata_i,
  input wire logic cfg_err_i
);
  import jtag_access_pkg::*;

  logic tck_s, tms_s, tdi_s, trst_n_s, bce_s, sdo_s, se_s, gts_s;
  logic tck_q_r;
  tap_state_t tap_r, tap_nxt;
  logic [IR_W-1:0] ir_sh_r, ir_r;
  logic [DR_W-1:0] dr_r;
  logic byp_r, tdo_r, tdo_oe_r;
  logic go_r, we_r, pend_r, ready_r, error_r;
  logic [DATA_W-1:0] rdata_r;

  // Each pin gets its own synchroniser; the second stage is the only one read.
  sync2 u_tck (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(tck_i), .q_o(tck_s));
  sync2 u_tms (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(tms_i), .q_o(tms_s));
  sync2 u_tdi (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(tdi_i), .q_o(tdi_s));
  sync2 u_trst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(test_reset_pin_n_i),
    .q_o(trst_n_s));
  sync2 u_bce (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(compliance_enable_pin_i),
    .q_o(bce_s));
  sync2 u_sdo (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(serdes_tdo_i), .q_o(sdo_s));
  sync2 u_se (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(scan_shift_enable_i),
    .q_o(se_s));
  sync2 u_gts (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(global_tristate_pin_i),
    .q_o(gts_s));

  wire tck_rise = tck_s & ~tck_q_r;
  wire tck_fall = ~tck_s & tck_q_r;
  // The pad pull-up keeps this high when unconnected, so the chain stays off.
  wire chained = ~bce_s;
  wire tdi_top = chained ? sdo_s : tdi_s;
  wire acc = (ir_r == IR_ACCESS);
  wire upd_dr = tck_rise && (tap_r == UP_DR) && acc;
  wire [ADDR_W-1:0] cmd_addr = dr_r[ADDR_LO +: ADDR_W];
  wire [DATA_W-1:0] cmd_wdata = dr_r[WDATA_LO +: DATA_W];

  // The SerDes TAP sees the raw pin; it runs on the test clock itself.
  assign serdes_tdi_o = tdi_i;
  assign scan_mode_o = ~se_s;
  assign bidir_force_input_o = ~gts_s;
  assign cfg_wr_o = go_r & we_r;
  assign cfg_rd_o = go_r & ~we_r;
  assign tdo_o = tdo_r;
  assign tdo_oe_o = tdo_oe_r;

  always_comb
  begin
    tap_nxt = tap_r;
    case (tap_r)
      TAP_RESET: tap_nxt = tms_s ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_nxt = tms_s ? SEL_DR : TAP_IDLE;
      SEL_DR: tap_nxt = tms_s ? SEL_IR : CAP_DR;
      CAP_DR: tap_nxt = tms_s ? EX1_DR : SH_DR;
      SH_DR: tap_nxt = tms_s ? EX1_DR : SH_DR;
      EX1_DR: tap_nxt = tms_s ? UP_DR : PA_DR;
      PA_DR: tap_nxt = tms_s ? EX2_DR : PA_DR;
      EX2_DR: tap_nxt = tms_s ? UP_DR : SH_DR;
      UP_DR: tap_nxt = tms_s ? SEL_DR : TAP_IDLE;
      SEL_IR: tap_nxt = tms_s ? TAP_RESET : CAP_IR;
      CAP_IR: tap_nxt = tms_s ? EX1_IR : SH_IR;
      SH_IR: tap_nxt = tms_s ? EX1_IR : SH_IR;
      EX1_IR: tap_nxt = tms_s ? UP_IR : PA_IR;
      PA_IR: tap_nxt = tms_s ? EX2_IR : PA_IR;
      EX2_IR: tap_nxt = tms_s ? UP_IR : SH_IR;
      UP_IR: tap_nxt = tms_s ? SEL_DR : TAP_IDLE;
      default: tap_nxt = TAP_RESET;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tck_q_r <= 1'b0;
      tap_r <= TAP_RESET;
    end
    else if (ce_i)
    begin
      tck_q_r <= tck_s;
      if (!trst_n_s)
        tap_r <= TAP_RESET;
      else if (tck_rise)
        tap_r <= tap_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ir_sh_r <= IR_BYPASS;
      ir_r <= IR_BYPASS;
    end
    else if (ce_i)
    begin
      if (!trst_n_s || tap_r == TAP_RESET)
        ir_r <= IR_BYPASS;
      else if (tck_rise && tap_r == UP_IR)
        ir_r <= ir_sh_r;
      if (tck_rise && tap_r == CAP_IR)
        ir_sh_r <= IR_CAPTURE;
      else if (tck_rise && tap_r == SH_IR)
        ir_sh_r <= {tdi_top, ir_sh_r[IR_W-1:1]};
    end
  end

  // Capture loads the result of the last access; shift moves it out LSB first.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dr_r <= '0;
      byp_r <= 1'b0;
    end
    else if (ce_i && tck_rise)
    begin
      if (tap_r == CAP_DR)
      begin
        byp_r <= 1'b0;
        if (acc)
        begin
          dr_r <= '0;
          dr_r[READY_POS] <= ready_r;
          dr_r[ERROR_POS] <= error_r;
          dr_r[RDATA_LO +: DATA_W] <= rdata_r;
        end
      end
      else if (tap_r == SH_DR)
      begin
        byp_r <= tdi_top;
        if (acc)
          dr_r <= {tdi_top, dr_r[DR_W-1:1]};
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end
    else if (ce_i && tck_fall)
    begin
      tdo_oe_r <= (tap_r == SH_DR) || (tap_r == SH_IR);
      if (tap_r == SH_IR)
        tdo_r <= ir_sh_r[0];
      else
        tdo_r <= acc ? dr_r[0] : byp_r;
    end
  end

  // Reads of performance registers go over the same port as single reads.
  // Nothing is retried, so an access never holds the bridge's own traffic.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      go_r <= 1'b0;
      we_r <= 1'b0;
      pend_r <= 1'b0;
      ready_r <= 1'b0;
      error_r <= 1'b0;
      rdata_r <= '0;
      cfg_addr_o <= '0;
      cfg_wdata_o <= '0;
    end
    else if (ce_i)
    begin
      go_r <= upd_dr;
      pend_r <= go_r;
      if (upd_dr)
      begin
        we_r <= dr_r[DIR_POS];
        cfg_addr_o <= cmd_addr;
        cfg_wdata_o <= cmd_wdata;
        ready_r <= 1'b0;
        error_r <= 1'b0;
      end
      else if (pend_r)
      begin
        ready_r <= 1'b1;
        error_r <= cfg_err_i;
        if (!we_r)
          rdata_r <= cfg_rdata_i;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_access_done: assert property ((cfg_wr_o || cfg_rd_o) && ce_i ##1 ce_i |=> ready_r)
    else $error("Ready not set after access.");
  a_ready_cleared: assert property (upd_dr && ce_i |=> !ready_r && go_r)
    else $error("Ready not cleared at launch.");
  a_single_strobe: assert property (!(cfg_wr_o && cfg_rd_o))
    else $error("Read and write strobes together.");
  a_ready_first: assert property (ce_i && tck_rise && tap_r == CAP_DR && acc
    |=> dr_r[READY_POS] == $past(ready_r)) else $error("Ready not in bit zero.");
  a_error_second: assert property (ce_i && tck_rise && tap_r == CAP_DR && acc
    |=> dr_r[ERROR_POS] == $past(error_r)) else $error("Error not in bit one.");
  a_read_data: assert property (cfg_rd_o && ce_i ##1 ce_i |=> rdata_r == $past(cfg_rdata_i))
    else $error("Read data not captured.");
  a_shift_lsb: assert property (ce_i && tck_rise && tap_r == SH_DR && acc
    |=> dr_r[DR_W-2:0] == $past(dr_r[DR_W-1:1])) else $error("Shift not LSB first.");
  a_trst_reset: assert property (ce_i && !trst_n_s |=> tap_r == TAP_RESET ##1 ir_r == IR_BYPASS
    || !ce_i) else $error("Test reset ignored.");
  a_bypass_zero: assert property (ce_i && tck_rise && tap_r == CAP_DR |=> !byp_r)
    else $error("Bypass capture not zero.");
endmodule
`default_nettype wire

// ---- verif/scan_host.sv ----
// Behavioural scan controller that drives the test pins of the access port.
// Assumes the caller keeps the TAP in Run-Test/Idle between calls.
`timescale 1ns/100ps
`default_nettype none
module scan_host (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // The test clock runs only inside a task and stands low between frames.
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #32 tck_o = 1'b1;
    tdo = tdo_i;
    #32 tck_o = 1'b0;
  endtask
  task automatic tap_reset();
    logic d;
    repeat (5) tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d);
  endtask
  task automatic idle(input int n);
    logic d;
    repeat (n) tick(1'b0, 1'b0, d);
  endtask
  task automatic scan(input logic ir, input int n, input logic [68:0] din,
                      output logic [68:0] dout);
    logic d;
    int i;
    dout = '0;
    tick(1'b1, 1'b0, d);
    if (ir)
    begin
      tick(1'b1, 1'b0, d);
    end
    tick(1'b0, 1'b0, d);
    tick(1'b0, 1'b0, d);
    for (i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], dout[i]);
    end
    tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d);
    tdi_o = ~tdi_o;
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Testbench for the test register access port with a small register responder.
// Assumes the scan host model drives the test pins.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import jtag_access_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic trst_n = 1'b1;
  logic bce = 1'b1;
  logic sse = 1'b1;
  logic gts = 1'b1;
  logic tck, tms, tdi, tdo, stdi, smode, bfi, toe, wr, rd, err = 1'b0;
  // The SerDes TAP is modelled as an inverter, so a chained path shows up as inverted bits.
  wire sdo = ~stdi;
  logic [9:0] addr;
  logic [31:0] wdata, rdata = 32'h0;
  logic [31:0] mem [0:1023];
  logic [68:0] o;
  int n_fail = 0;
  int n_checks = 0;
  always #2 clk_i = ~clk_i;
  scan_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
  jtag_register_access_port DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .test_reset_pin_n_i(trst_n),
    .compliance_enable_pin_i(bce), .serdes_tdo_i(sdo), .scan_shift_enable_i(sse),
    .global_tristate_pin_i(gts), .serdes_tdi_o(stdi), .tdo_o(tdo), .tdo_oe_o(toe),
    .scan_mode_o(smode), .bidir_force_input_o(bfi), .cfg_wr_o(wr), .cfg_rd_o(rd),
    .cfg_addr_o(addr), .cfg_wdata_o(wdata), .cfg_rdata_i(rdata), .cfg_err_i(err));
  // Read data is fresh only after a read strobe; otherwise it keeps toggling.
  always @(posedge clk_i)
  begin
    if (wr)
    begin
      mem[addr] <= wdata;
    end
    rdata <= rd ? mem[addr] : ~rdata;
    err <= (wr | rd) & (addr == 10'h3FF);
  end
  function automatic logic [68:0] cmd(input logic [9:0] a, input logic w,
                                      input logic [31:0] d);
    return {5'h00, a, w, d, 21'h000000};
  endfunction
  task automatic chk(input logic [68:0] seen, input logic [68:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(smode, 1'b0);
    chk(bfi, 1'b0);
    sse <= 1'b0;
    gts <= 1'b0;
    bce <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(smode, 1'b1);
    chk(bfi, 1'b1);
    chk(stdi, tdi);
    sse <= 1'b1;
    gts <= 1'b1;
    bce <= 1'b1;
    $display("test pins done");
    // The host's edges are kept one nanosecond off the system clock edges.
    #1;
    host.tap_reset();
    host.scan(1'b1, IR_W, 69'(IR_ACCESS), o);
    host.scan(1'b0, DR_W, cmd(10'h005, 1'b1, 32'hA5C3_0F96), o);
    chk(toe, 1'b0);
    host.idle(IDLE_MIN_TCK);
    host.scan(1'b0, DR_W, cmd(10'h005, 1'b0, 32'h0), o);
    chk(o[1:0], 2'b01);
    chk(mem[5], 32'hA5C3_0F96);
    host.idle(IDLE_MIN_TCK);
    host.scan(1'b0, DR_W, cmd(10'h3FF, 1'b1, 32'h1), o);
    chk(o, {35'h0, 32'hA5C3_0F96, 2'b01});
    chk(addr, 10'h3FF);
    host.idle(IDLE_MIN_TCK);
    host.scan(1'b0, DR_W, cmd(10'h000, 1'b0, 32'h0), o);
    chk(o[1:0], 2'b11);
    $display("test access done");
    host.scan(1'b1, IR_W, 69'h0, o);
    host.scan(1'b0, 8, 69'hB5, o);
    chk(o[7:0], 8'h6A);
    host.scan(1'b1, IR_W, 69'(IR_ACCESS), o);
    @(posedge clk_i);
    trst_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    trst_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    host.idle(1);
    host.scan(1'b0, 8, 69'hB5, o);
    chk(o[7:0], 8'h6A);
    $display("test bypass done");
    @(posedge clk_i);
    bce <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    host.scan(1'b0, 8, 69'hB5, o);
    chk(o[7:0], 8'h94);
    $display("test chain done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
